// ---- design/regulator_level_registers.sv ----
/*
 Byte-wide control register bank for the second core rail, the external converter link and two linear regulators.
 Assumes both register ports are synchronous to CLK, one access per port per cycle, boot values stable at BOOT_LOAD.
*/
`timescale 1ns/1ps
module regulator_level_registers (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic BOOT_LOAD,
    input wire logic [7:0] BOOT_CORE2_PRIMARY,
    input wire logic [7:0] BOOT_CORE2_ALT,
    input wire logic [1:0] BOOT_EXT_MODE,
    input wire logic [7:0] BOOT_EXT_PRIMARY,
    input wire logic [7:0] BOOT_LIN_ONE,
    input wire logic [7:0] BOOT_LIN_TWO,
    input wire logic [1:0] CORE2_GAIN,
    input wire logic CTL_WR,
    input wire logic CTL_RD,
    input wire logic [7:0] CTL_ADDR,
    input wire logic [7:0] CTL_WDATA,
    output logic [7:0] CTL_RDATA,
    input wire logic SCL_WR,
    input wire logic SCL_RD,
    input wire logic [7:0] SCL_ADDR,
    input wire logic [7:0] SCL_WDATA,
    output logic [7:0] SCL_RDATA,
    output logic [15:0] CORE2_LEVEL_MV,
    output logic EXT_ON,
    output logic EXT_ENABLE,
    output logic [7:0] EXT_RATIO_NUM,
    output logic [7:0] EXT_RATIO_DEN,
    output logic [15:0] LIN_ONE_MV,
    output logic LIN_ONE_ON,
    output logic LIN_ONE_SLEEP,
    output logic [15:0] LIN_TWO_MV,
    output logic LIN_TWO_ON,
    output logic LIN_TWO_SLEEP
);
    logic [7:0] core2_primary_q, core2_primary_d;
    logic [6:0] core2_alternate_level_q, core2_alternate_level_d;
    logic [1:0] ext_converter_power_q, ext_converter_power_d;
    logic [7:0] ext_converter_primary_level_q, ext_converter_primary_level_d;
    logic [6:0] ext_converter_alternate_level_q, ext_converter_alternate_level_d;
    logic [7:0] linear_reg_one_ctl_q, linear_reg_one_ctl_d;
    logic [7:0] linear_reg_two_ctl_q, linear_reg_two_ctl_d;
    logic path_choice_bit_q, path_choice_bit_d;
    logic [15:0] core2_mv_q;
    logic ext_enable_q;
    logic [7:0] ext_num_q, ext_den_q;
    logic [7:0] ctl_rdata_q, scl_rdata_q;

    // The voltage-scaling port owns the level registers when the path choice bit is set.
    wire scl_owns = path_choice_bit_q;
    wire ctl_owns = ~path_choice_bit_q;

    // Write strobes for registers shared between the two ports.
    wire ctl_wr_lvl = CTL_WR & ctl_owns;
    wire scl_wr_lvl = SCL_WR & scl_owns;
    wire [7:0] lvl_addr = scl_wr_lvl ? SCL_ADDR : CTL_ADDR;
    wire [7:0] lvl_data = scl_wr_lvl ? SCL_WDATA : CTL_WDATA;
    wire lvl_wr = ctl_wr_lvl | scl_wr_lvl;
    wire wr_core2_primary = lvl_wr & (lvl_addr == regbank_pkg::CORE2_PRIMARY_OFFSET);
    wire wr_core2_alt = lvl_wr & (lvl_addr == regbank_pkg::CORE2_ALT_OFFSET);
    wire wr_ext_primary = lvl_wr & (lvl_addr == regbank_pkg::EXT_PRIMARY_OFFSET);
    wire wr_ext_alt = lvl_wr & (lvl_addr == regbank_pkg::EXT_ALT_OFFSET);

    // Mode, linear regulator and path registers answer only on the control port.
    wire wr_ext_power = CTL_WR & (CTL_ADDR == regbank_pkg::EXT_POWER_OFFSET);
    wire wr_lin_one = CTL_WR & (CTL_ADDR == regbank_pkg::LIN_ONE_OFFSET);
    wire wr_lin_two = CTL_WR & (CTL_ADDR == regbank_pkg::LIN_TWO_OFFSET);
    wire wr_path = CTL_WR & (CTL_ADDR == regbank_pkg::PATH_SEL_OFFSET);

    // Next values: a host write wins over a boot reload in the same cycle, since software acts later in intent.
    always_comb begin
        core2_primary_d = core2_primary_q;
        core2_alternate_level_d = core2_alternate_level_q;
        ext_converter_power_d = ext_converter_power_q;
        ext_converter_primary_level_d = ext_converter_primary_level_q;
        ext_converter_alternate_level_d = ext_converter_alternate_level_q;
        linear_reg_one_ctl_d = linear_reg_one_ctl_q;
        linear_reg_two_ctl_d = linear_reg_two_ctl_q;
        path_choice_bit_d = path_choice_bit_q;
        if (BOOT_LOAD) begin
            core2_primary_d = BOOT_CORE2_PRIMARY;
            core2_alternate_level_d = BOOT_CORE2_ALT[6:0];
            ext_converter_power_d = BOOT_EXT_MODE;
            ext_converter_primary_level_d = BOOT_EXT_PRIMARY;
            linear_reg_one_ctl_d = BOOT_LIN_ONE;
            linear_reg_two_ctl_d = BOOT_LIN_TWO;
        end
        if (wr_core2_primary) begin
            core2_primary_d = lvl_data;
        end
        if (wr_core2_alt) begin
            core2_alternate_level_d = lvl_data[6:0];
        end
        if (wr_ext_primary) begin
            ext_converter_primary_level_d = lvl_data;
        end
        if (wr_ext_alt) begin
            ext_converter_alternate_level_d = lvl_data[6:0];
        end
        if (wr_ext_power) begin
            ext_converter_power_d = CTL_WDATA[1:0];
        end
        if (wr_lin_one) begin
            linear_reg_one_ctl_d = CTL_WDATA;
        end
        if (wr_lin_two) begin
            linear_reg_two_ctl_d = CTL_WDATA;
        end
        if (wr_path) begin
            path_choice_bit_d = CTL_WDATA[regbank_pkg::PATH_CHOICE_BIT];
        end
    end

    // Register storage; boot values arrive through BOOT_LOAD after reset release, never at reset itself.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            core2_primary_q <= regbank_pkg::ZERO_RESET;
            core2_alternate_level_q <= 7'h00;
            ext_converter_power_q <= 2'h0;
            ext_converter_primary_level_q <= regbank_pkg::ZERO_RESET;
            ext_converter_alternate_level_q <= regbank_pkg::EXT_ALT_RESET[6:0];
            linear_reg_one_ctl_q <= regbank_pkg::ZERO_RESET;
            linear_reg_two_ctl_q <= regbank_pkg::ZERO_RESET;
            path_choice_bit_q <= 1'b0;
        end else begin
            core2_primary_q <= core2_primary_d;
            core2_alternate_level_q <= core2_alternate_level_d;
            ext_converter_power_q <= ext_converter_power_d;
            ext_converter_primary_level_q <= ext_converter_primary_level_d;
            ext_converter_alternate_level_q <= ext_converter_alternate_level_d;
            linear_reg_one_ctl_q <= linear_reg_one_ctl_d;
            linear_reg_two_ctl_q <= linear_reg_two_ctl_d;
            path_choice_bit_q <= path_choice_bit_d;
        end
    end

    // Read multiplexer; reserved bits are padded with zero.
    function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic lvl_ok, input logic ctl_port);
        logic [7:0] r;
        r = 8'h00;
        if (lvl_ok && addr == regbank_pkg::CORE2_PRIMARY_OFFSET) begin
            r = core2_primary_q;
        end else if (lvl_ok && addr == regbank_pkg::CORE2_ALT_OFFSET) begin
            r = {1'b0, core2_alternate_level_q};
        end else if (lvl_ok && addr == regbank_pkg::EXT_PRIMARY_OFFSET) begin
            r = ext_converter_primary_level_q;
        end else if (lvl_ok && addr == regbank_pkg::EXT_ALT_OFFSET) begin
            r = {1'b0, ext_converter_alternate_level_q};
        end else if (ctl_port && addr == regbank_pkg::EXT_POWER_OFFSET) begin
            r = {6'h00, ext_converter_power_q};
        end else if (ctl_port && addr == regbank_pkg::LIN_ONE_OFFSET) begin
            r = linear_reg_one_ctl_q;
        end else if (ctl_port && addr == regbank_pkg::LIN_TWO_OFFSET) begin
            r = linear_reg_two_ctl_q;
        end else if (ctl_port && addr == regbank_pkg::PATH_SEL_OFFSET) begin
            r = {7'h00, path_choice_bit_q};
        end
        return r;
    endfunction

    // A process rather than a continuous assignment, so the mux also follows the registers read inside the function.
    logic [7:0] ctl_rd_d, scl_rd_d;
    always_comb begin
        ctl_rd_d = read_mux(CTL_ADDR, ctl_owns, 1'b1);
        scl_rd_d = read_mux(SCL_ADDR, scl_owns, 1'b0);
    end

    // Read data are captured on the edge that samples the strobe and then held.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctl_rdata_q <= 8'h00;
            scl_rdata_q <= 8'h00;
        end else begin
            if (CTL_RD) ctl_rdata_q <= ctl_rd_d;
            if (SCL_RD) scl_rdata_q <= scl_rd_d;
        end
    end

    // Core rail two: the apply bit picks the active code.
    wire [6:0] core2_code = core2_primary_q[regbank_pkg::APPLY_ALT_BIT] ? core2_alternate_level_q
                                                                          : core2_primary_q[6:0];
    // Formula in microvolts, then scaled to millivolts; 12.5 mV steps stay exact at 0.5 mV rounding down.
    wire [31:0] core2_uv = 32'(core2_code) * 32'(regbank_pkg::CORE2_STEP_UV) + 32'(regbank_pkg::CORE2_BASE_UV);
    wire [15:0] core2_lin_mv = 16'(core2_uv / 32'd1000);
    wire [2:0] gain = (CORE2_GAIN == 2'h3) ? 3'h3 : (CORE2_GAIN == 2'h2) ? 3'h2 : 3'h1;
    wire [15:0] core2_req_d = (core2_code == 7'h00) ? 16'h0000 :
                              (core2_code < regbank_pkg::CORE2_MIN_CODE) ? regbank_pkg::CORE2_MIN_MV :
                              (core2_code >= regbank_pkg::CORE2_MAX_CODE) ? regbank_pkg::CORE2_MAX_MV :
                              16'(core2_lin_mv * 16'(gain));

    // External converter: active code from primary or alternate register.
    wire [6:0] ext_code = ext_converter_primary_level_q[regbank_pkg::APPLY_ALT_BIT]
                          ? ext_converter_alternate_level_q : ext_converter_primary_level_q[6:0];
    wire ext_on_d = ext_converter_power_q[0];
    wire ext_unity = (ext_code <= regbank_pkg::EXT_UNITY_CODE);
    wire ext_sat = (ext_code >= regbank_pkg::EXT_MAX_CODE);
    wire [7:0] ext_num_d = ext_unity ? 8'h01 : ext_sat ? regbank_pkg::EXT_SAT_NUM : regbank_pkg::EXT_NUM;
    wire [7:0] ext_den_d = ext_unity ? 8'h01 : ext_sat ? regbank_pkg::EXT_SAT_DEN
                                             : 8'(regbank_pkg::EXT_DEN_BASE + 8'(ext_code));
    wire ext_enable_d = ext_on_d & (ext_code != 7'h00);

    // Output registers for the derived requests.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            core2_mv_q <= 16'h0000;
            ext_enable_q <= 1'b0;
            ext_num_q <= 8'h01;
            ext_den_q <= 8'h01;
        end else begin
            core2_mv_q <= core2_req_d;
            ext_enable_q <= ext_enable_d;
            ext_num_q <= ext_num_d;
            ext_den_q <= ext_den_d;
        end
    end

    rail_mode_decode ext_mode (
        .clk(CLK),
        .resetn(RESETN),
        .rail_on_mode(ext_converter_power_q),
        .on_q(EXT_ON),
        .low_power_q()
    );

    // Linear regulator modes: 01 active, 11 sleep, otherwise off.
    rail_mode_decode lin_one_mode (
        .clk(CLK),
        .resetn(RESETN),
        .rail_on_mode(linear_reg_one_ctl_q[1:0]),
        .on_q(LIN_ONE_ON),
        .low_power_q(LIN_ONE_SLEEP)
    );

    rail_mode_decode lin_two_mode (
        .clk(CLK),
        .resetn(RESETN),
        .rail_on_mode(linear_reg_two_ctl_q[1:0]),
        .on_q(LIN_TWO_ON),
        .low_power_q(LIN_TWO_SLEEP)
    );

    linear_level_map lin_one_level (
        .clk(CLK),
        .resetn(RESETN),
        .level_code(linear_reg_one_ctl_q[7:2]),
        .level_mv_q(LIN_ONE_MV)
    );

    linear_level_map lin_two_level (
        .clk(CLK),
        .resetn(RESETN),
        .level_code(linear_reg_two_ctl_q[7:2]),
        .level_mv_q(LIN_TWO_MV)
    );

    assign CTL_RDATA = ctl_rdata_q;
    assign SCL_RDATA = scl_rdata_q;
    assign CORE2_LEVEL_MV = core2_mv_q;
    assign EXT_ENABLE = ext_enable_q;
    assign EXT_RATIO_NUM = ext_num_q;
    assign EXT_RATIO_DEN = ext_den_q;
endmodule

// ---- design/regbank_pkg.sv ----
/*
 Holds the register map, field positions, reset values and conversion constants of the regulator level bank.
 Assumes every user refers to these names through the package scope.
*/
package regbank_pkg;
    // Byte offsets on the register port.
    localparam logic [7:0] CORE2_PRIMARY_OFFSET = 8'h25;
    localparam logic [7:0] CORE2_ALT_OFFSET = 8'h26;
    localparam logic [7:0] EXT_POWER_OFFSET = 8'h27;
    localparam logic [7:0] EXT_PRIMARY_OFFSET = 8'h28;
    localparam logic [7:0] EXT_ALT_OFFSET = 8'h29;
    localparam logic [7:0] LIN_ONE_OFFSET = 8'h30;
    localparam logic [7:0] LIN_TWO_OFFSET = 8'h31;
    localparam logic [7:0] PATH_SEL_OFFSET = 8'h3F;
    // Field positions.
    localparam int APPLY_ALT_BIT = 7;
    localparam int PATH_CHOICE_BIT = 0;
    // Reset values; EXT_ALT_RESET is for the one level field that no boot image covers.
    localparam logic [7:0] EXT_ALT_RESET = 8'h03;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    // Core rail two level coding, limits in millivolts, step and base in microvolts.
    localparam logic [6:0] CORE2_MIN_CODE = 7'h03;
    localparam logic [6:0] CORE2_MAX_CODE = 7'h4B;
    localparam logic [15:0] CORE2_MIN_MV = 16'h0258;
    localparam logic [15:0] CORE2_MAX_MV = 16'h05DC;
    localparam int CORE2_STEP_UV = 12500;
    localparam int CORE2_BASE_UV = 562500;
    // External converter divider coding: ratio = num / den.
    localparam logic [6:0] EXT_UNITY_CODE = 7'h03;
    localparam logic [6:0] EXT_MAX_CODE = 7'h43;
    localparam logic [7:0] EXT_NUM = 8'h30;
    localparam logic [7:0] EXT_DEN_BASE = 8'h2D;
    localparam logic [7:0] EXT_SAT_NUM = 8'h03;
    localparam logic [7:0] EXT_SAT_DEN = 8'h07;
    // Linear regulator coding, millivolts.
    localparam logic [5:0] LIN_FLOOR_CODE = 6'h04;
    localparam logic [5:0] LIN_MAX_CODE = 6'h32;
    localparam logic [15:0] LIN_FLOOR_MV = 16'h03E8;
    localparam logic [15:0] LIN_STEP_MV = 16'h0032;
endpackage

// ---- design/rail_mode_decode.sv ----
/*
 Decodes a two-bit rail on mode field into on and low-power flags, registered.
 Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module rail_mode_decode (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] rail_on_mode,
    output logic on_q,
    output logic low_power_q
);
    // Bit 0 alone decides on; bit 1 only matters when on.
    wire on_d = rail_on_mode[0];
    wire low_power_d = rail_on_mode[0] & rail_on_mode[1];

    // Registered so the outputs of the top stay flip-flop driven.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            on_q <= 1'b0;
            low_power_q <= 1'b0;
        end else begin
            on_q <= on_d;
            low_power_q <= low_power_d;
        end
    end
endmodule

// ---- design/linear_level_map.sv ----
/*
 Maps a six-bit linear regulator level code to a requested voltage in millivolts, registered.
 Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module linear_level_map (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] level_code,
    output logic [15:0] level_mv_q
);
    // Codes at or under the floor all ask for the floor voltage; codes past the top clamp there.
    wire [5:0] clamped = (level_code > regbank_pkg::LIN_MAX_CODE) ? regbank_pkg::LIN_MAX_CODE : level_code;
    wire [5:0] steps = (clamped > regbank_pkg::LIN_FLOOR_CODE) ? 6'(clamped - regbank_pkg::LIN_FLOOR_CODE) : 6'h00;
    wire [15:0] level_d = 16'(regbank_pkg::LIN_FLOOR_MV + 16'(steps) * regbank_pkg::LIN_STEP_MV);

    // One step per code above the floor.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_mv_q <= 16'h0000;
        end else begin
            level_mv_q <= level_d;
        end
    end
endmodule

// ---- tb/regulator_level_registers_asserts.sv ----
/* Concurrent checks on the ports of the regulator level bank, judged on control-port writes and reads.
   Assumes the bind below, the package compiled first, and one clock with an active-low reset. */
`timescale 1ns/1ps
module regulator_level_registers_asserts (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic BOOT_LOAD,
    input wire logic CTL_WR,
    input wire logic CTL_RD,
    input wire logic [7:0] CTL_ADDR,
    input wire logic [7:0] CTL_WDATA,
    input wire logic [7:0] CTL_RDATA,
    input wire logic [15:0] CORE2_LEVEL_MV,
    input wire logic EXT_ON,
    input wire logic [7:0] EXT_RATIO_NUM,
    input wire logic [7:0] EXT_RATIO_DEN,
    input wire logic [15:0] LIN_ONE_MV,
    input wire logic LIN_ONE_ON,
    input wire logic LIN_ONE_SLEEP
);
    logic path_q;
    logic wr;
    // Mirror of the path choice bit, so level writes count only while the control port owns them.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            path_q <= 1'b0;
        end else if (CTL_WR && CTL_ADDR == regbank_pkg::PATH_SEL_OFFSET) begin
            path_q <= CTL_WDATA[0];
        end
    end
    // A boot load in the same cycle loses to the host; it is kept out to stay clear of that race.
    assign wr = CTL_WR && !BOOT_LOAD;
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // A write reaches its register on the first edge and the derived output on the second.
    sequence lin_s; wr && CTL_ADDR == 8'h30; endsequence
    sequence core2_s; wr && !path_q && CTL_ADDR == regbank_pkg::CORE2_PRIMARY_OFFSET && !CTL_WDATA[7]; endsequence
    sequence ext_s; wr && !path_q && CTL_ADDR == regbank_pkg::EXT_PRIMARY_OFFSET && !CTL_WDATA[7]; endsequence
    lin_mode_a: assert property (lin_s |-> ##2
        LIN_ONE_ON == $past(CTL_WDATA[0], 2) && LIN_ONE_SLEEP == &$past(CTL_WDATA[1:0], 2))
        else $error("Linear one mode flags wrong.");
    lin_floor_a: assert property ((lin_s ##0 (CTL_WDATA[7:2] <= 6'h04)) |-> ##2 LIN_ONE_MV == 16'h03E8)
        else $error("Linear one floor level wrong.");
    lin_step_a: assert property ((lin_s ##0 (CTL_WDATA[7:2] inside {[6'h05:6'h32]})) |-> ##2
        LIN_ONE_MV == 16'(1000 + 50 * ($past(CTL_WDATA[7:2], 2) - 4)))
        else $error("Linear one step level wrong.");
    ext_on_a: assert property (wr && CTL_ADDR == 8'h27 |=> ##1 EXT_ON == $past(CTL_WDATA[0], 2))
        else $error("Converter on flag wrong.");
    rsv_read_a: assert property (CTL_RD && CTL_ADDR == 8'h27 |=> CTL_RDATA[7:2] == 6'h00)
        else $error("Reserved bits read nonzero.");
    core2_off_a: assert property ((core2_s ##0 (CTL_WDATA[6:0] == 7'h00)) |-> ##2 CORE2_LEVEL_MV == 16'h0000)
        else $error("Core rail two not off.");
    core2_sat_a: assert property ((core2_s ##0 (CTL_WDATA[6:0] >= 7'h4B)) |-> ##2 CORE2_LEVEL_MV == 16'h05DC)
        else $error("Core rail two not saturated.");
    ext_sat_a: assert property ((ext_s ##0 (CTL_WDATA[6:0] >= 7'h43)) |-> ##2
        EXT_RATIO_NUM == 8'h03 && EXT_RATIO_DEN == 8'h07)
        else $error("Converter ratio not at minimum.");
endmodule
bind regulator_level_registers regulator_level_registers_asserts i_regulator_level_registers_asserts (
    .CLK(CLK), .RESETN(RESETN), .BOOT_LOAD(BOOT_LOAD), .CTL_WR(CTL_WR), .CTL_RD(CTL_RD), .CTL_ADDR(CTL_ADDR),
    .CTL_WDATA(CTL_WDATA), .CTL_RDATA(CTL_RDATA), .CORE2_LEVEL_MV(CORE2_LEVEL_MV), .EXT_ON(EXT_ON),
    .EXT_RATIO_NUM(EXT_RATIO_NUM), .EXT_RATIO_DEN(EXT_RATIO_DEN), .LIN_ONE_MV(LIN_ONE_MV),
    .LIN_ONE_ON(LIN_ONE_ON), .LIN_ONE_SLEEP(LIN_ONE_SLEEP));

// ---- tb/register_host.sv ----
/* Host model driving the control and voltage-scaling register ports of the bank.
   Assumes the bank samples strobes on the rising edge and answers reads one cycle later. */
`timescale 1ns/1ps
module register_host (
    input wire logic clk,
    input wire logic [7:0] ctl_rdata,
    input wire logic [7:0] scl_rdata,
    output logic ctl_wr,
    output logic ctl_rd,
    output logic [7:0] ctl_addr,
    output logic [7:0] ctl_wdata,
    output logic scl_wr,
    output logic scl_rd,
    output logic [7:0] scl_addr,
    output logic [7:0] scl_wdata
);
    // Both ports idle from time zero.
    initial begin
        {ctl_wr, ctl_rd, scl_wr, scl_rd} = 4'h0;
        {ctl_addr, ctl_wdata, scl_addr, scl_wdata} = 32'h0;
    end
    // One access on either or both ports; s is control write, control read, scaling write, scaling read.
    // Address and data are inverted once strobes drop, so a bank that samples them late sees garbage.
    task automatic acc(input logic [3:0] s, input logic [7:0] ca, input logic [7:0] cd, input logic [7:0] sa,
                       input logic [7:0] sd, output logic [7:0] cq, output logic [7:0] sq);
        @(negedge clk);
        {ctl_wr, ctl_rd, scl_wr, scl_rd} = s;
        {ctl_addr, ctl_wdata, scl_addr, scl_wdata} = {ca, cd, sa, sd};
        @(posedge clk);
        @(negedge clk);
        {ctl_wr, ctl_rd, scl_wr, scl_rd} = 4'h0;
        {ctl_addr, ctl_wdata, scl_addr, scl_wdata} = ~{ca, cd, sa, sd};
        cq = ctl_rdata;
        sq = scl_rdata;
    endtask
endmodule

// ---- tb/regulator_level_registers_test.sv ----
/* Self-checking bench for the regulator level bank: boot load, level codes, port ownership, reserved bits.
   Assumes the package, the design, the host model and the checker are compiled ahead of it. */
`timescale 1ns/1ps
module regulator_level_registers_test;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic boot_load = 1'b0;
    logic [7:0] b_c2p = 8'h00, b_c2a = 8'h00, b_ep = 8'h00, b_l1 = 8'h00, b_l2 = 8'h00, cq, sq, r_num, r_den;
    logic [1:0] b_em = 2'h0, gain = 2'h0;
    logic ctl_wr, ctl_rd, scl_wr, scl_rd, ext_on, ext_en, l1_on, l1_sl, l2_on, l2_sl;
    logic [7:0] ctl_addr, ctl_wdata, scl_addr, scl_wdata, ctl_rdata, scl_rdata;
    logic [15:0] c2_mv, l1_mv, l2_mv;
    logic [31:0] rnd = 32'h007F4E4C;
    int err_total = 0, check_count = 0, cycles = 0;
    regulator_level_registers i_regulator_level_registers (
        .CLK(clk), .RESETN(resetn), .BOOT_LOAD(boot_load), .BOOT_CORE2_PRIMARY(b_c2p), .BOOT_CORE2_ALT(b_c2a),
        .BOOT_EXT_MODE(b_em), .BOOT_EXT_PRIMARY(b_ep), .BOOT_LIN_ONE(b_l1), .BOOT_LIN_TWO(b_l2), .CORE2_GAIN(gain),
        .CTL_WR(ctl_wr), .CTL_RD(ctl_rd), .CTL_ADDR(ctl_addr), .CTL_WDATA(ctl_wdata), .CTL_RDATA(ctl_rdata),
        .SCL_WR(scl_wr), .SCL_RD(scl_rd), .SCL_ADDR(scl_addr), .SCL_WDATA(scl_wdata), .SCL_RDATA(scl_rdata),
        .CORE2_LEVEL_MV(c2_mv), .EXT_ON(ext_on), .EXT_ENABLE(ext_en), .EXT_RATIO_NUM(r_num), .EXT_RATIO_DEN(r_den),
        .LIN_ONE_MV(l1_mv), .LIN_ONE_ON(l1_on), .LIN_ONE_SLEEP(l1_sl), .LIN_TWO_MV(l2_mv), .LIN_TWO_ON(l2_on),
        .LIN_TWO_SLEEP(l2_sl));
    register_host i_register_host (.clk(clk), .ctl_rdata(ctl_rdata), .scl_rdata(scl_rdata), .ctl_wr(ctl_wr),
        .ctl_rd(ctl_rd), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .scl_wr(scl_wr), .scl_rd(scl_rd),
        .scl_addr(scl_addr), .scl_wdata(scl_wdata));
    // Clock, and a cycle ceiling far above the seventeen hundred or so cycles the tests take.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            results();
        end
    end
    // Pseudo-random source, and expected levels in millivolts or as numerator and denominator.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] core2_mv(input logic [6:0] c, input logic [1:0] g);
        return c == 0 ? 16'h0000 : c < 3 ? 16'h0258 : c >= 75 ? 16'h05DC : 16'((c * 125 + 5625) / 10 * (g[1] ? g : 1));
    endfunction
    function automatic logic [15:0] lin_mv(input logic [5:0] c);
        return c <= 4 ? 16'h03E8 : c >= 50 ? 16'h0CE4 : 16'(1000 + 50 * (c - 4));
    endfunction
    function automatic logic [15:0] ratio(input logic [6:0] c);
        return c <= 3 ? 16'h0101 : c >= 67 ? 16'h0307 : {8'h30, 8'(45 + c)};
    endfunction
    // Compare and count; a mismatch is reported at once.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
        i_register_host.acc(p ? 4'b0010 : 4'b1000, a, d, a, d, cq, sq);
    endtask
    task automatic rchk(input logic p, input logic [7:0] a, input logic [7:0] e);
        i_register_host.acc(p ? 4'b0001 : 4'b0100, a, 8'h00, a, 8'h00, cq, sq);
        chk(p ? sq : cq, e);
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence; outputs are read two falling edges after a write so the output flops have landed.
    initial begin
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        rchk(0, 8'h29, 8'h03);
        chk({r_num, r_den}, 16'h0101);
        $display("reset test done");
        rnd = lfsr(rnd);
        {b_c2p, b_c2a, b_ep, b_l1} = rnd;
        rnd = lfsr(rnd);
        {b_l2, b_em} = rnd[9:0];
        boot_load = 1'b1;
        @(negedge clk);
        boot_load = 1'b0;
        rchk(0, 8'h26, b_c2a & 8'h7F);
        rchk(0, 8'h27, {6'h00, b_em});
        rchk(0, 8'h31, b_l2);
        chk(l1_mv, lin_mv(b_l1[7:2]));
        $display("boot test done");
        for (int i = 0; i < 64; i++) begin
            rnd = lfsr(rnd);
            wr(0, 8'h30, {i[5:0], rnd[1:0]});
            wr(0, 8'h31, rnd[9:2]);
            repeat (2) @(negedge clk);
            chk(l1_mv, lin_mv(i[5:0]));
            chk({l1_on, l1_sl}, {rnd[0], &rnd[1:0]});
            chk(l2_mv, lin_mv(rnd[9:4]));
            chk({l2_on, l2_sl}, {rnd[2], &rnd[3:2]});
        end
        $display("linear test done");
        for (int i = 0; i < 128; i++) begin
            rnd = lfsr(rnd);
            gain = rnd[1:0];
            wr(0, regbank_pkg::CORE2_PRIMARY_OFFSET, {1'b0, i[6:0]});
            repeat (2) @(negedge clk);
            chk(c2_mv, core2_mv(i[6:0], rnd[1:0]));
        end
        $display("core rail test done");
        for (int i = 0; i < 128; i++) begin
            rnd = lfsr(rnd);
            wr(0, 8'h27, rnd[7:0]);
            wr(0, regbank_pkg::EXT_PRIMARY_OFFSET, {1'b0, i[6:0]});
            repeat (2) @(negedge clk);
            chk(ext_on, rnd[0]);
            chk(ext_en, rnd[0] && i != 0);
            chk({r_num, r_den}, ratio(i[6:0]));
        end
        $display("converter test done");
        wr(0, regbank_pkg::PATH_SEL_OFFSET, 8'h01);
        wr(0, 8'h29, 8'h05);
        rchk(0, 8'h29, 8'h00);
        rnd = lfsr(rnd);
        wr(1, 8'h29, rnd[7:0] | 8'h80);
        rchk(1, 8'h29, rnd[7:0] & 8'h7F);
        wr(1, regbank_pkg::EXT_PRIMARY_OFFSET, 8'h80);
        wr(1, regbank_pkg::CORE2_ALT_OFFSET, rnd[15:8]);
        wr(1, regbank_pkg::CORE2_PRIMARY_OFFSET, 8'h80);
        repeat (2) @(negedge clk);
        chk({r_num, r_den}, ratio(rnd[6:0]));
        chk(c2_mv, core2_mv(rnd[14:8], gain));
        i_register_host.acc(4'b1010, 8'h29, 8'h11, 8'h29, 8'h22, cq, sq);
        rchk(1, 8'h29, 8'h22);
        wr(0, 8'h27, 8'hFF);
        rchk(0, 8'h27, 8'h03);
        rchk(0, 8'h50, 8'h00);
        rchk(1, 8'h30, 8'h00);
        // A reset in mid-run must hand the level registers back to the control port.
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        rchk(0, 8'h29, 8'h03);
        chk(l1_mv, 16'h03E8);
        $display("port test done");
        results();
    end
endmodule
